/* core/mba_arbiter.sv */
/*
 Memory bus arbiter and peripheral bridge for a Harvard core with
 five access sources onto one target. Several instances, one per
 target, let accesses to different targets proceed in the same cycle.
 Assumes the core holds a request steady until its grant.
*/
`timescale 1ns/1ps
`include "mba_params.svh"
module mba_arbiter #(
	parameter int PERI_WIDE = 1
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Source requests, index order as in the params header
	input wire logic [`MBA_N_SRC-1:0] req_i,
	input wire logic [`MBA_DADDR_W-1:0] dwr_addr_i,
	input wire logic [`MBA_DATA_W-1:0] dwr_data_i,
	input wire logic dwr_wide_i,
	input wire logic [`MBA_PADDR_W-1:0] pwr_addr_i,
	input wire logic [`MBA_DATA_W-1:0] pwr_data_i,
	input wire logic [`MBA_DADDR_W-1:0] drd_addr_i,
	input wire logic drd_wide_i,
	input wire logic [`MBA_PADDR_W-1:0] prd_addr_i,
	input wire logic [`MBA_PADDR_W-1:0] fet_addr_i,
	input wire logic protect_i,
	output logic [`MBA_N_SRC-1:0] grant_o,
	output logic [`MBA_N_SRC-1:0] stall_o,
	output logic [`MBA_DATA_W-1:0] rd_data_o,
	output logic rd_valid_o,
	// Peripheral side
	output logic peri_en_o,
	output logic peri_we_o,
	output logic peri_wide_o,
	output logic [`MBA_PERI_AW-1:0] peri_addr_o,
	output logic [`MBA_DATA_W-1:0] peri_wdata_o,
	input wire logic [`MBA_DATA_W-1:0] peri_rdata_i,
	input wire logic peri_ready_i
);
	// Only 0 (16-bit only) and 1 (16- and 32-bit) name a bus flavour
	if (PERI_WIDE != 0 && PERI_WIDE != 1) begin : g_bad_flavour
		$error("PERI_WIDE must be 0 or 1");
	end

	// Winner of this cycle, one-hot or zero
	logic [`MBA_N_SRC-1:0] pick;
	// Some higher-priority source is asking
	logic [`MBA_N_SRC-1:0] ahead;
	// The winner is a read that must let a finished write settle first
	logic hold_off;
	// An access starts on the coming edge
	logic start;
	// The current access completes in this cycle
	logic done;

	// Sequencing state
	mba_pkg::mba_state_t st_r, st_nxt;
	logic [`MBA_N_SRC-1:0] grant_r, grant_nxt;
	logic busy_r, busy_nxt;
	logic wr_pend_r, wr_pend_nxt;

	// Access launched on the peripheral side
	logic we_r, we_nxt;
	logic wide_r, wide_nxt;
	logic [`MBA_PERI_AW-1:0] addr_r, addr_nxt;
	logic [`MBA_DATA_W-1:0] wdata_r, wdata_nxt;

	// Read return
	logic [`MBA_DATA_W-1:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;

	// Fixed priority: lowest index wins
	assign ahead[0] = 1'b0;
	for (genvar g = 1; g < `MBA_N_SRC; g++) begin : g_ahead
		assign ahead[g] = ahead[g-1] | req_i[g-1];
	end
	for (genvar g = 0; g < `MBA_N_SRC; g++) begin : g_pick
		assign pick[g] = req_i[g] & ~ahead[g];
	end

	// A protected read waits one slot behind a finished write
	// The cost is one idle cycle, paid only inside protected regions.
	assign hold_off = protect_i && wr_pend_r &&
		(pick[`MBA_SRC_DRD] || pick[`MBA_SRC_PRD]);
	assign start = (st_r == mba_pkg::MBA_IDLE) && (pick != '0) && !hold_off;
	assign done = (st_r == mba_pkg::MBA_WAIT) && peri_ready_i;

	// Sequencing: one access per target at a time
	always_comb begin
		st_nxt = st_r;
		grant_nxt = grant_r;
		busy_nxt = busy_r;
		wr_pend_nxt = wr_pend_r;
		case (st_r)
			mba_pkg::MBA_IDLE: begin
				// The pending mark covers exactly one idle slot
				wr_pend_nxt = 1'b0;
				grant_nxt = '0;
				if (start) begin
					st_nxt = mba_pkg::MBA_WAIT;
					busy_nxt = 1'b1;
					grant_nxt = pick;
				end
			end
			mba_pkg::MBA_WAIT: begin
				if (done) begin
					st_nxt = mba_pkg::MBA_IDLE;
					busy_nxt = 1'b0;
					grant_nxt = '0;
					// Remember a finished write for the protected-read check
					wr_pend_nxt = we_r;
				end
			end
			default: begin
				st_nxt = mba_pkg::MBA_IDLE;
				busy_nxt = 1'b0;
				grant_nxt = '0;
				wr_pend_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			st_r <= mba_pkg::MBA_IDLE;
			grant_r <= '0;
			busy_r <= 1'b0;
			wr_pend_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			grant_r <= grant_nxt;
			busy_r <= busy_nxt;
			wr_pend_r <= wr_pend_nxt;
		end
	end

	// Access fields are captured once and stand until the target is ready
	always_comb begin
		we_nxt = we_r;
		wide_nxt = wide_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		if (start) begin
			// Only one write source can be live at once
			we_nxt = pick[`MBA_SRC_DWR] | pick[`MBA_SRC_PWR];
			// Legacy flavour forces 16-bit accesses
			wide_nxt = (PERI_WIDE != 0) &&
				((pick[`MBA_SRC_DWR] && dwr_wide_i) ||
				(pick[`MBA_SRC_DRD] && drd_wide_i));
			// Bridge keeps the low address bits
			case (1'b1)
				pick[`MBA_SRC_DWR]: addr_nxt = dwr_addr_i[`MBA_PERI_AW-1:0];
				pick[`MBA_SRC_PWR]: addr_nxt = pwr_addr_i[`MBA_PERI_AW-1:0];
				pick[`MBA_SRC_DRD]: addr_nxt = drd_addr_i[`MBA_PERI_AW-1:0];
				pick[`MBA_SRC_PRD]: addr_nxt = prd_addr_i[`MBA_PERI_AW-1:0];
				default: addr_nxt = fet_addr_i[`MBA_PERI_AW-1:0];
			endcase
			wdata_nxt = pick[`MBA_SRC_DWR] ? dwr_data_i : pwr_data_i;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			we_r <= 1'b0;
			wide_r <= 1'b0;
			addr_r <= '0;
			wdata_r <= '0;
		end else begin
			we_r <= we_nxt;
			wide_r <= wide_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
		end
	end

	// Read data is kept until the next read completes
	always_comb begin
		rdata_nxt = rdata_r;
		rvalid_nxt = 1'b0;
		if (done && !we_r) begin
			rvalid_nxt = 1'b1;
			// Narrow access returns the low half, upper half zero
			rdata_nxt = wide_r ? peri_rdata_i :
				{16'h0000, peri_rdata_i[15:0]};
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_r <= '0;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// Completion pulses the grant; losers keep stalling
	// Other targets have their own instance, so they run in the same cycle.
	assign grant_o = done ? grant_r : '0;
	assign stall_o = req_i & ~grant_o;
	assign peri_en_o = busy_r;
	assign peri_we_o = we_r;
	assign peri_wide_o = wide_r;
	assign peri_addr_o = addr_r;
	assign peri_wdata_o = wdata_r;
	assign rd_data_o = rdata_r;
	assign rd_valid_o = rvalid_r;
endmodule : mba_arbiter

/* include/mba_params.svh */
/*
 Constants for the memory bus arbiter and peripheral bridge.
 Assumes inclusion by bare name from the core and checker files only.
*/
// What this block does
// - Priority: dwrite, pwrite, dread, pread, fetch
// - Program read: 22-bit address, 16-bit data
// - Data paths: 32-bit address and data
// - Fetch, read, write together on different targets
// - Bridge folds buses onto 16-bit-address peripheral bus
// - Legacy peripheral flavour: 16-bit accesses only
// - Other flavour: 16- and 32-bit accesses
// - Protected region: write stays before later read
`ifndef MBA_PARAMS_SVH
`define MBA_PARAMS_SVH
`define MBA_PADDR_W 22
`define MBA_DADDR_W 32
`define MBA_DATA_W 32
`define MBA_PERI_AW 16
`define MBA_N_SRC 5
`define MBA_SRC_DWR 0
`define MBA_SRC_PWR 1
`define MBA_SRC_DRD 2
`define MBA_SRC_PRD 3
`define MBA_SRC_FET 4
`endif

/* include/mba_pkg.sv */
/*
 Types for the memory bus arbiter.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package mba_pkg;
	typedef enum logic [1:0] {
		MBA_IDLE = 2'b00,
		MBA_WAIT = 2'b01
	} mba_state_t;
endpackage : mba_pkg

/* dv/mba_arbiter_chk.sv */
/* Port checker for mba_arbiter. Assumes binding to each arbiter. */
`timescale 1ns/1ps
`include "mba_params.svh"
module mba_arbiter_chk (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [`MBA_N_SRC-1:0] req_i,
	input wire logic [`MBA_N_SRC-1:0] grant_o,
	input wire logic [`MBA_N_SRC-1:0] stall_o,
	input wire logic rd_valid_o,
	input wire logic peri_en_o,
	input wire logic peri_we_o,
	input wire logic peri_wide_o,
	input wire logic [`MBA_PERI_AW-1:0] peri_addr_o,
	input wire logic peri_ready_i
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	sequence s_wait; peri_en_o && !peri_ready_i; endsequence
	property p_stall; req_i[0] && !peri_en_o |=> peri_en_o; endproperty
	property p_one; $onehot0(grant_o); endproperty
	property p_take; $rose(peri_en_o) |-> peri_we_o == $past(|req_i[1:0]); endproperty
	property p_hold; s_wait |=> peri_en_o && $stable(peri_addr_o); endproperty
	property p_grant; |grant_o |-> peri_en_o && peri_ready_i; endproperty
	property p_gap; |grant_o |=> !peri_en_o; endproperty
	property p_rdv; |grant_o[4:2] |=> rd_valid_o; endproperty
	property p_pnar; grant_o[1] |-> peri_we_o && !peri_wide_o; endproperty
	a_stall: assert property (p_stall) else $error("stall");
	a_one: assert property (p_one) else $error("grants");
	a_take: assert property (p_take) else $error("order");
	a_hold: assert property (p_hold) else $error("hold");
	a_grant: assert property (p_grant) else $error("grant");
	a_gap: assert property (p_gap) else $error("gap");
	a_rdv: assert property (p_rdv) else $error("valid");
	a_pnar: assert property (p_pnar) else $error("pwrite");
endmodule : mba_arbiter_chk
bind mba_arbiter mba_arbiter_chk i_mba_arbiter_chk (.*);

/* dv/mba_periph_model.sv */
/* Peripheral target with wait states. Assumes the arbiter holds peri_* until ready. */
`timescale 1ns/1ps
module mba_periph_model (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic en_i,
	input wire logic we_i,
	input wire logic [15:0] addr_i,
	input wire logic [1:0] wait_i,
	output logic ready_o,
	output logic [31:0] rdata_o
);
	logic [1:0] cnt_r;
	// Idle lines swap halves so stale data never looks valid
	assign rdata_o = (en_i && !we_i) ? {~addr_i, addr_i} : {addr_i, ~addr_i};
	assign ready_o = en_i && cnt_r == wait_i;
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i || !en_i || ready_o) cnt_r <= 2'h0;
		else cnt_r <= cnt_r + 2'h1;
	end
endmodule : mba_periph_model

/* dv/tb_mba_arbiter.sv */
/* Bench for mba_arbiter. Assumes the model and checker files. */
`timescale 1ns/1ps
module tb_mba_arbiter;
	logic clk_sys_i = 0, reset_i = 1, protect_i = 0, dwr_wide_i = 0, drd_wide_i = 0;
	logic [4:0] req_i = 0, grant_o, stall_o;
	logic [31:0] dwr_addr_i = 32'h0000_1234, dwr_data_i = 32'h5a5a_0f0f;
	logic [31:0] drd_addr_i = 32'h0000_beef, pwr_data_i = 32'h0000_c3c3;
	logic [21:0] pwr_addr_i = 22'h00_0042, prd_addr_i = 22'h00_0077, fet_addr_i = 22'h00_0099;
	logic [31:0] rd_data_o, peri_wdata_o, peri_rdata_i;
	logic [15:0] peri_addr_o;
	logic [1:0] wait_c = 0;
	logic rd_valid_o, peri_en_o, peri_we_o, peri_wide_o, peri_ready_i;
	int n_mismatch = 0, comparisons = 0, cyc = 0;
	mba_arbiter #(.PERI_WIDE(1)) i_mba_arbiter (.*);
	mba_periph_model i_mba_periph_model (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.en_i(peri_en_o), .we_i(peri_we_o), .addr_i(peri_addr_o), .wait_i(wait_c),
		.ready_o(peri_ready_i), .rdata_o(peri_rdata_i));
	initial forever #10 clk_sys_i = ~clk_sys_i;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic close_out();
		$display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : close_out
	// Waits for the next grant, checks the access on show, then drops that request
	task automatic take(input int s, output int k);
		logic [15:0] a_exp;
		k = 0;
		do @(negedge clk_sys_i); while (grant_o === 5'h00 && ++k < 20);
		case (s)
			0: a_exp = dwr_addr_i[15:0];
			1: a_exp = pwr_addr_i[15:0];
			2: a_exp = drd_addr_i[15:0];
			3: a_exp = prd_addr_i[15:0];
			default: a_exp = fet_addr_i[15:0];
		endcase
		chk(grant_o, 32'h1 << s);
		chk(stall_o, req_i & ~(5'h01 << s));
		chk(peri_addr_o, a_exp);
		chk(peri_we_o, s < 2);
		if (s < 2) chk(peri_wdata_o, s == 0 ? dwr_data_i : pwr_data_i);
		@(posedge clk_sys_i) req_i <= req_i & ~grant_o;
	endtask : take
	task automatic t_prio_fast();
		int k;
		@(posedge clk_sys_i) req_i <= 5'b0_1101;
		protect_i <= 1;
		take(0, k);
		take(2, k);
		chk(k, 2);
		take(3, k);
		chk(k, 1);
		protect_i <= 0;
	endtask : t_prio_fast
	task automatic t_prio_slow();
		int k;
		@(posedge clk_sys_i) wait_c <= 2;
		req_i <= 5'b1_0110;
		take(1, k);
		take(2, k);
		take(4, k);
		wait_c <= 0;
	endtask : t_prio_slow
	task automatic t_read(input logic wide);
		int k;
		@(posedge clk_sys_i) drd_wide_i <= wide;
		req_i <= 5'b0_0100;
		take(2, k);
		@(negedge clk_sys_i);
		chk(rd_valid_o, 1);
		chk(peri_wide_o, wide);
		chk(rd_data_o, {wide ? 16'h4110 : 16'h0000, 16'hbeef});
	endtask : t_read
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_mismatch++;
			close_out();
		end
	end
	initial begin
		repeat (2) @(posedge clk_sys_i);
		reset_i <= 0;
		t_prio_fast();
		t_prio_slow();
		t_read(1);
		t_read(0);
		close_out();
	end
endmodule : tb_mba_arbiter
